// ### logic/instr_exec_map.svh
// Constants for the move/return instruction execution block
`ifndef INSTR_EXEC_MAP_SVH
`define INSTR_EXEC_MAP_SVH
`define IRQ_ENABLE_BIT   7
`define IRQ_CTRL_RESET   8'h00
`define PTR_RESET        16'h0000
`define BANK_RESET       5'h00
`define OPTION_RESET     8'hff
`define ACC_RESET        8'h00
`define FILE_ADDR_MAX    7'h7f
`define RET_CYCLES       2
`define RESET_HOLD       4
`endif

// ### logic/instr_exec_pkg.sv
// Types for the move/return instruction execution block
package instr_exec_pkg;
   typedef enum logic [3:0] {
      OP_NOP,
      OP_MOVE_FILE,
      OP_MOVE_INDIRECT,
      OP_MOVE_INDIRECT_OFS,
      OP_LOAD_BANK,
      OP_RETURN_IRQ,
      OP_RETURN_LITERAL,
      OP_LOAD_OPTION,
      OP_SOFT_RESET
   } op_t;
   typedef enum logic [1:0] {
      MODE_PRE_INC,
      MODE_PRE_DEC,
      MODE_POST_INC,
      MODE_POST_DEC
   } ptr_mode_t;
   typedef enum {
      ST_EXEC,
      ST_RET_SECOND,
      ST_RESET_HOLD
   } state_t;
endpackage

// ### logic/ptr_step_if.sv
// Carrier between the executor and the pointer update unit
`timescale 1ns/1ns
`default_nettype none
interface ptr_step_if;
   import instr_exec_pkg::*;
   logic [15:0] ptr;
   ptr_mode_t   mode;
   logic        relative;
   logic [5:0]  offset;
   logic [15:0] effAddr;
   logic [15:0] newPtr;
   modport exec (output ptr, mode, relative, offset, input effAddr, newPtr);
   modport unit (input ptr, mode, relative, offset, output effAddr, newPtr);
endinterface
`default_nettype wire

// ### logic/ptr_step.sv
// Effective address and pointer update for indirect moves
`timescale 1ns/1ns
`default_nettype none
module ptr_step (
   ptr_step_if.unit p
);
   import instr_exec_pkg::*;
   logic [15:0] stepped;
   logic [15:0] ofsExt;
   always_comb begin
      // 16-bit arithmetic wraps at both ends
      stepped = p.mode[0] ? p.ptr - 16'h0001 : p.ptr + 16'h0001;     // RULE7
      ofsExt  = {{10{p.offset[5]}}, p.offset};
      if (p.relative) begin
         p.effAddr = p.ptr + ofsExt;                                  // RULE4
         p.newPtr  = p.ptr;                                           // RULE4
      end else begin
         p.effAddr = p.mode[1] ? p.ptr : stepped;                     // RULE3
         p.newPtr  = stepped;                                         // RULE3
      end
   end
endmodule
`default_nettype wire

// ### logic/instr_exec.sv
// Execution of move, indirect move, bank, return, option and reset instructions
// Summary of operation
// (RULE1) Move file register to accumulator or itself
// (RULE2) File move updates zero flag
// (RULE3) Indirect move with pre/post inc/dec pointer
// (RULE4) Relative offset form leaves pointer unchanged
// (RULE5) Indirect window accesses pointer-addressed location
// (RULE6) Pointers hold 16-bit addresses
// (RULE7) Pointer increment and decrement wrap around
// (RULE8) Bank literal loads bank register, flags kept
// (RULE9) Return from irq pops stack, sets enable
// (RULE10) Return literal loads accumulator and pops stack
// (RULE11) Option load copies accumulator, flags kept
// (RULE12) Software reset resets device, clears flag
// (RULE13) Software reset equals hardware reset
// (RULE14) Zero flag set when moved value zero
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_map.svh"
module instr_exec (
   input  wire logic                core_clk,
   input  wire logic                resetn,
   input  wire logic                instrValid,
   input  wire instr_exec_pkg::op_t opcode,
   input  wire logic [6:0]          fileAddr,
   input  wire logic                destFile,
   input  wire logic                ptrSel,
   input  wire instr_exec_pkg::ptr_mode_t ptrMode,
   input  wire logic [7:0]          literal,
   input  wire logic                toFile,
   input  wire logic [7:0]          fileRdata,
   input  wire logic [7:0]          dataRdata,
   input  wire logic [14:0]         stackTop,
   output logic                     busy,
   output logic                     fileWe,
   output logic [6:0]               fileWaddr,
   output logic [7:0]               fileWdata,
   output logic                     dataWe,
   output logic [15:0]              dataAddr,
   output logic [7:0]               dataWdata,
   output logic [7:0]               acc,
   output logic                     zeroFlag,
   output logic [15:0]              indirectPointer0,
   output logic [15:0]              indirectPointer1,
   output logic [4:0]               bankSelectReg,
   output logic [7:0]               irqControlReg,
   output logic [7:0]               optionReg,
   output logic                     stackPop,
   output logic                     pcLoad,
   output logic [14:0]              pcValue,
   output logic                     softResetFlagN,
   output logic                     deviceResetReq
);
   import instr_exec_pkg::*;

   state_t      state;
   state_t      next_state;
   logic [1:0]  holdCnt;
   logic [1:0]  next_holdCnt;
   logic        next_busy;
   logic        next_fileWe;
   logic [6:0]  next_fileWaddr;
   logic [7:0]  next_fileWdata;
   logic        next_dataWe;
   logic [15:0] next_dataAddr;
   logic [7:0]  next_dataWdata;
   logic [7:0]  next_acc;
   logic        next_zeroFlag;
   logic [15:0] next_ptr0;
   logic [15:0] next_ptr1;
   logic [4:0]  next_bank;
   logic [7:0]  next_irqCtrl;
   logic [7:0]  next_option;
   logic        next_stackPop;
   logic        next_pcLoad;
   logic [14:0] next_pcValue;
   logic        next_softResetFlagN;
   logic        next_deviceResetReq;
   logic [7:0]  moved;

   ptr_step_if step ();
   ptr_step u_ptr_step (
      .p (step.unit)
   );

   always_comb begin
      step.ptr      = ptrSel ? indirectPointer1 : indirectPointer0;  // RULE6
      step.mode     = ptrMode;
      step.relative = (opcode == OP_MOVE_INDIRECT_OFS);
      step.offset   = literal[5:0];
   end

   always_comb begin
      next_state          = state;
      next_holdCnt        = holdCnt;
      next_busy           = 1'b0;
      next_fileWe         = 1'b0;
      next_fileWaddr      = fileWaddr;
      next_fileWdata      = fileWdata;
      next_dataWe         = 1'b0;
      next_dataAddr       = dataAddr;
      next_dataWdata      = dataWdata;
      next_acc            = acc;
      next_zeroFlag       = zeroFlag;
      next_ptr0           = indirectPointer0;
      next_ptr1           = indirectPointer1;
      next_bank           = bankSelectReg;
      next_irqCtrl        = irqControlReg;
      next_option         = optionReg;
      next_stackPop       = 1'b0;
      next_pcLoad         = 1'b0;
      next_pcValue        = pcValue;
      next_softResetFlagN = softResetFlagN;
      next_deviceResetReq = 1'b0;
      moved               = 8'h00;
      unique case (state)
         ST_EXEC: begin
            if (instrValid) begin
               unique case (opcode)
                  OP_MOVE_FILE: begin
                     moved = fileRdata;
                     if (destFile) begin
                        next_fileWe    = 1'b1;                         // RULE1
                        next_fileWaddr = fileAddr;
                        next_fileWdata = moved;
                     end else begin
                        next_acc = moved;                              // RULE1
                     end
                     next_zeroFlag = (moved == 8'h00);                 // RULE2 RULE14
                  end
                  OP_MOVE_INDIRECT, OP_MOVE_INDIRECT_OFS: begin
                     // Window has no storage: go straight to the pointed location
                     next_dataAddr = step.effAddr;                     // RULE5
                     if (toFile) begin
                        moved          = acc;
                        next_dataWe    = 1'b1;
                        next_dataWdata = acc;
                     end else begin
                        moved    = dataRdata;
                        next_acc = dataRdata;
                     end
                     next_zeroFlag = (moved == 8'h00);                 // RULE3 RULE14
                     if (ptrSel)
                        next_ptr1 = step.newPtr;                       // RULE3
                     else
                        next_ptr0 = step.newPtr;
                  end
                  OP_LOAD_BANK: next_bank = literal[4:0];              // RULE8
                  OP_RETURN_IRQ: begin
                     next_stackPop           = 1'b1;                   // RULE9
                     next_pcLoad             = 1'b1;
                     next_pcValue            = stackTop;
                     next_irqCtrl[`IRQ_ENABLE_BIT] = 1'b1;             // RULE9
                     next_busy               = 1'b1;
                     next_state              = ST_RET_SECOND;
                  end
                  OP_RETURN_LITERAL: begin
                     next_acc      = literal;                          // RULE10
                     next_stackPop = 1'b1;
                     next_pcLoad   = 1'b1;
                     next_pcValue  = stackTop;
                     next_busy     = 1'b1;
                     next_state    = ST_RET_SECOND;                    // RULE10
                  end
                  OP_LOAD_OPTION: next_option = acc;                   // RULE11
                  OP_SOFT_RESET: begin
                     next_softResetFlagN = 1'b0;                       // RULE12
                     next_deviceResetReq = 1'b1;
                     next_busy           = 1'b1;
                     next_holdCnt        = 2'(`RESET_HOLD - 1);
                     next_state          = ST_RESET_HOLD;
                  end
                  OP_NOP: ;
                  default: ;
               endcase
            end
         end
         ST_RET_SECOND: next_state = ST_EXEC;                          // RULE9 RULE10
         ST_RESET_HOLD: begin
            // Same register state as a hardware reset; cause flag survives
            next_busy           = 1'b1;
            next_deviceResetReq = 1'b1;
            next_acc            = `ACC_RESET;                          // RULE13
            next_zeroFlag       = 1'b0;
            next_ptr0           = `PTR_RESET;
            next_ptr1           = `PTR_RESET;
            next_bank           = `BANK_RESET;
            next_irqCtrl        = `IRQ_CTRL_RESET;
            next_option         = `OPTION_RESET;
            next_pcLoad         = 1'b1;
            next_pcValue        = 15'h0000;
            next_holdCnt        = holdCnt - 2'd1;
            if (holdCnt == 2'd0) begin
               next_busy           = 1'b0;
               next_deviceResetReq = 1'b0;
               next_pcLoad         = 1'b0;
               next_state          = ST_EXEC;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state            <= ST_EXEC;
         holdCnt          <= 2'd0;
         busy             <= 1'b0;
         fileWe           <= 1'b0;
         fileWaddr        <= 7'h00;
         fileWdata        <= 8'h00;
         dataWe           <= 1'b0;
         dataAddr         <= 16'h0000;
         dataWdata        <= 8'h00;
         acc              <= `ACC_RESET;
         zeroFlag         <= 1'b0;
         indirectPointer0 <= `PTR_RESET;
         indirectPointer1 <= `PTR_RESET;
         bankSelectReg    <= `BANK_RESET;
         irqControlReg    <= `IRQ_CTRL_RESET;
         optionReg        <= `OPTION_RESET;
         stackPop         <= 1'b0;
         pcLoad           <= 1'b0;
         pcValue          <= 15'h0000;
         softResetFlagN   <= 1'b1;
         deviceResetReq   <= 1'b0;
      end else begin
         state            <= next_state;
         holdCnt          <= next_holdCnt;
         busy             <= next_busy;
         fileWe           <= next_fileWe;
         fileWaddr        <= next_fileWaddr;
         fileWdata        <= next_fileWdata;
         dataWe           <= next_dataWe;
         dataAddr         <= next_dataAddr;
         dataWdata        <= next_dataWdata;
         acc              <= next_acc;
         zeroFlag         <= next_zeroFlag;
         indirectPointer0 <= next_ptr0;
         indirectPointer1 <= next_ptr1;
         bankSelectReg    <= next_bank;
         irqControlReg    <= next_irqCtrl;
         optionReg        <= next_option;
         stackPop         <= next_stackPop;
         pcLoad           <= next_pcLoad;
         pcValue          <= next_pcValue;
         softResetFlagN   <= next_softResetFlagN;
         deviceResetReq   <= next_deviceResetReq;
      end
   end
endmodule
`default_nettype wire

// ### sim/instr_exec_sva.sv
// Checker for the move/return execution block
`timescale 1ns/1ns
`default_nettype none
module instr_exec_sva (
   input wire logic                core_clk,
   input wire logic                resetn,
   input wire logic                instrValid,
   input wire logic                destFile,
   input wire logic                ptrSel,
   input wire logic                busy,
   input wire logic                fileWe,
   input wire logic                zeroFlag,
   input wire logic                stackPop,
   input wire logic                pcLoad,
   input wire logic                softResetFlagN,
   input wire logic                deviceResetReq,
   input wire instr_exec_pkg::op_t opcode,
   input wire logic [6:0]          fileAddr,
   input wire logic [6:0]          fileWaddr,
   input wire logic [7:0]          fileRdata,
   input wire logic [7:0]          literal,
   input wire logic [7:0]          fileWdata,
   input wire logic [7:0]          acc,
   input wire logic [7:0]          irqControlReg,
   input wire logic [7:0]          optionReg,
   input wire logic [14:0]         stackTop,
   input wire logic [14:0]         pcValue,
   input wire logic [15:0]         indirectPointer0,
   input wire logic [15:0]         dataAddr,
   input wire logic [4:0]          bankSelectReg
);
   import instr_exec_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic        t;
   logic [15:0] ofs;
   assign t = instrValid && !busy;
   assign ofs = {{10{literal[5]}}, literal[5:0]};
   sequence s_pop; stackPop && pcLoad && pcValue == $past(stackTop) && busy; endsequence
   sequence s_end; !stackPop && !pcLoad && !busy; endsequence
   property p_mv_acc; t && opcode == OP_MOVE_FILE && !destFile |=> acc == $past(fileRdata) && !fileWe; endproperty
   a_mv_acc: assert property (p_mv_acc) else $error("move to acc");
   property p_mv_file; t && opcode == OP_MOVE_FILE && destFile |=> fileWe && fileWaddr == $past(fileAddr)
      && fileWdata == $past(fileRdata) && zeroFlag == ($past(fileRdata) == 8'h00); endproperty
   a_mv_file: assert property (p_mv_file) else $error("move to file");
   property p_ofs; t && opcode == OP_MOVE_INDIRECT_OFS && !ptrSel
      |=> $stable(indirectPointer0) && dataAddr == $past(indirectPointer0) + $past(ofs); endproperty
   a_ofs: assert property (p_ofs) else $error("offset move");
   property p_bank; t && opcode == OP_LOAD_BANK |=> bankSelectReg == $past(literal[4:0]) && $stable(zeroFlag); endproperty
   a_bank: assert property (p_bank) else $error("bank load");
   property p_rirq; t && opcode == OP_RETURN_IRQ |=> (irqControlReg[7] && $stable(zeroFlag)) ##0 s_pop ##1 s_end;
   endproperty
   a_rirq: assert property (p_rirq) else $error("return irq");
   property p_rlit; t && opcode == OP_RETURN_LITERAL
      |=> (acc == $past(literal) && $stable(zeroFlag)) ##0 s_pop ##1 s_end; endproperty
   a_rlit: assert property (p_rlit) else $error("return literal");
   property p_opt; t && opcode == OP_LOAD_OPTION |=> optionReg == $past(acc) && $stable(zeroFlag); endproperty
   a_opt: assert property (p_opt) else $error("option load");
   sequence s_hold; deviceResetReq && !softResetFlagN && busy; endsequence
   sequence s_free; !deviceResetReq && !busy && acc == 8'h00 && optionReg == 8'hff; endsequence
   property p_srst; t && opcode == OP_SOFT_RESET |=> s_hold [*4] ##1 s_free; endproperty
   a_srst: assert property (p_srst) else $error("soft reset");
endmodule
`default_nettype wire

// ### sim/cpu_move_return_instr_subset_bench.sv
// Self-checking bench for the move/return execution block
`timescale 1ns/1ns
`default_nettype none
module cpu_move_return_instr_subset_bench;
   import instr_exec_pkg::*;
   logic        core_clk = 1'b0, resetn = 1'b0, instrValid = 1'b0, destFile = 1'b0, ptrSel = 1'b0, toFile = 1'b0;
   op_t         opcode = OP_NOP;
   ptr_mode_t   ptrMode = MODE_PRE_INC;
   logic [6:0]  fileAddr = 7'h00;
   logic [7:0]  literal = 8'h00, fileRdata = 8'h00, dataRdata = 8'h00;
   logic [14:0] stackTop = 15'h5abc;
   logic        busy, fileWe, dataWe, zeroFlag, stackPop, pcLoad, softResetFlagN, deviceResetReq;
   logic [6:0]  fileWaddr;
   logic [7:0]  fileWdata, dataWdata, acc, irqControlReg, optionReg;
   logic [15:0] dataAddr, indirectPointer0, indirectPointer1;
   logic [4:0]  bankSelectReg;
   logic [14:0] pcValue;
   int          failures = 0, total_checks = 0, cycles = 0;
   instr_exec dut (.*);
   always #4 core_clk = ~core_clk;
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // Valid stays high so operations run back to back
   task automatic run_op(input op_t op, input logic [7:0] lit, input logic [7:0] rd);
      opcode = op;
      literal = lit;
      fileRdata = rd;
      dataRdata = rd;
      instrValid = 1'b1;
      @(posedge core_clk);
      #1;
   endtask
   task automatic t_move;
      fileAddr = 7'h7f;
      destFile = 1'b1;
      run_op(OP_MOVE_FILE, 8'h00, 8'h00);
      chk(fileWe === 1'b1 && fileWaddr === 7'h7f && fileWdata === 8'h00 && zeroFlag === 1'b1, "self move");
      destFile = 1'b0;
      run_op(OP_MOVE_FILE, 8'h00, 8'ha5);
      chk(acc === 8'ha5 && fileWe === 1'b0 && zeroFlag === 1'b0, "move to acc");
      $display("move done");
   endtask
   task automatic t_indirect;
      ptr_mode_t   md [4] = '{MODE_PRE_DEC, MODE_PRE_INC, MODE_POST_INC, MODE_POST_DEC};
      logic [15:0] ea [4] = '{16'hffff, 16'h0000, 16'h0000, 16'h0001};
      logic [15:0] np [4] = '{16'hffff, 16'h0000, 16'h0001, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         ptrMode = md[i];
         run_op(OP_MOVE_INDIRECT, 8'h00, 8'(i));
         chk(dataAddr === ea[i] && indirectPointer0 === np[i], "pointer");
         chk(acc === 8'(i) && zeroFlag === (i == 0), "read");
      end
      ptrSel = 1'b1;
      toFile = 1'b1;
      ptrMode = MODE_PRE_INC;
      run_op(OP_MOVE_INDIRECT, 8'h00, 8'h00);
      chk(dataWe === 1'b1 && dataAddr === 16'h0001 && dataWdata === 8'h03 && indirectPointer1 === 16'h0001
         && indirectPointer0 === 16'h0000, "write");
      ptrSel = 1'b0;
      toFile = 1'b0;
      run_op(OP_MOVE_INDIRECT_OFS, 8'h20, 8'h44);
      chk(dataAddr === 16'hffe0 && indirectPointer0 === 16'h0000 && acc === 8'h44, "offset low");
      run_op(OP_MOVE_INDIRECT_OFS, 8'h1f, 8'h45);
      chk(dataAddr === 16'h001f && indirectPointer0 === 16'h0000, "offset high");
      $display("indirect done");
   endtask
   task automatic t_returns;
      run_op(OP_MOVE_FILE, 8'h00, 8'h00);
      run_op(OP_LOAD_BANK, 8'h1f, 8'h00);
      chk(bankSelectReg === 5'h1f && zeroFlag === 1'b1, "bank");
      run_op(OP_RETURN_LITERAL, 8'h5a, 8'h00);
      chk(acc === 8'h5a && zeroFlag === 1'b1 && busy === 1'b1, "retlit");
      chk(stackPop === 1'b1 && pcLoad === 1'b1 && pcValue === 15'h5abc, "retlit pop");
      run_op(OP_LOAD_BANK, 8'h03, 8'h00);
      chk(bankSelectReg === 5'h1f && busy === 1'b0 && pcLoad === 1'b0, "refused");
      run_op(OP_LOAD_OPTION, 8'h00, 8'h00);
      chk(optionReg === 8'h5a && zeroFlag === 1'b1, "option");
      run_op(OP_RETURN_IRQ, 8'h00, 8'h00);
      chk(irqControlReg[7] === 1'b1 && pcLoad === 1'b1 && pcValue === 15'h5abc && busy === 1'b1, "retirq");
      run_op(OP_NOP, 8'h00, 8'h00);
      $display("returns done");
   endtask
   task automatic t_soft;
      run_op(OP_SOFT_RESET, 8'h00, 8'h00);
      instrValid = 1'b0;
      chk(softResetFlagN === 1'b0 && deviceResetReq === 1'b1 && busy === 1'b1, "soft start");
      repeat (3) @(posedge core_clk);
      #1;
      chk(busy === 1'b1 && deviceResetReq === 1'b1 && pcLoad === 1'b1 && pcValue === 15'h0000, "soft hold");
      @(posedge core_clk);
      #1;
      chk(busy === 1'b0 && deviceResetReq === 1'b0 && acc === 8'h00 && bankSelectReg === 5'h00 && optionReg === 8'hff
         && irqControlReg === 8'h00 && indirectPointer1 === 16'h0000 && softResetFlagN === 1'b0, "soft end");
      $display("soft reset done");
   endtask
   // Mid-run hardware reset restores the cause flag
   task automatic t_hw_reset;
      run_op(OP_LOAD_BANK, 8'h0a, 8'h00);
      instrValid = 1'b0;
      resetn = 1'b0;
      @(posedge core_clk);
      #1;
      chk(bankSelectReg === 5'h00 && softResetFlagN === 1'b1 && optionReg === 8'hff && busy === 1'b0, "hw reset");
      resetn = 1'b1;
      run_op(OP_LOAD_BANK, 8'h15, 8'h00);
      chk(bankSelectReg === 5'h15 && softResetFlagN === 1'b1 && busy === 1'b0, "after reset");
      instrValid = 1'b0;
      $display("hw reset done");
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      #1 resetn = 1'b1;
      t_move();
      t_indirect();
      t_returns();
      t_soft();
      t_hw_reset();
      print_verdict();
   end
endmodule
bind instr_exec instr_exec_sva u_sva (.*);
`default_nettype wire
